// *** design/ulpi_phy_startup.sv ***
`include "ulpi_su_cfg.svh"

// Function
// - Release needs power-on reset and pin high
// - Core supply up loads register defaults
// - Pin low pulse resets registers, machines
// - Link always drives the reset pin
// - Link holds reset until supplies stable
// - Reset mode; no analog supply zeroes lines (lines not zeroed in reset mode from io supply loss alone)
// - Default operating state is synchronous mode
// - Start needs supplies, clock, pin high
// - Reset release accepted at any phase
// - Idle data and DIR high until lock
// - After lock, DIR falls once STP low
// - Link drives idle cycle after DIR falls
// - Start-up timed from first clock activity
// - Link biases ID, waits, reads status
// - ID status zero grounded, one floating
// - ID pulled low raises interrupt unbiased
// - ID status is interrupt status bit four
module ulpi_phy_startup
  import ulpi_su_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic core_supply_ok_i,
  input wire logic io_supply_ok_i,
  input wire logic analog_supply_ok_i,
  input wire logic ref_clk_active_i,
  input wire logic pll_locked_i,
  input wire logic id_pin_i,
  input wire logic [1:0] line_raw_i,
  ulpi_su_if.phy lnk,
  output logic in_reset_o,
  output logic sync_mode_o,
  output logic id_bias_o,
  output logic id_grounded_o,
  output logic [1:0] line_state_o
);

  phy_state_e state_r;
  phy_state_e state_nxt;
  logic ext_meta_r;
  logic ext_sync_r;
  logic dir_r;
  logic id_prev_r;
  logic id_int_r;
  ulpi_byte_t regs_r [0:1];
  ulpi_byte_t otg_nxt;
  ulpi_byte_t stat_nxt;
  logic hold_reset;
  logic supplies_ok;
  logic dir_nxt;
  logic id_fall;
  logic [1:0] lines;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
    end
    else if (ce_i)
    begin
      ext_meta_r <= lnk.ext_reset_n;
      ext_sync_r <= ext_meta_r;
    end
  end

  assign hold_reset = !ext_sync_r || !core_supply_ok_i;
  assign supplies_ok = core_supply_ok_i && io_supply_ok_i;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PHY_RESET:
        state_nxt = PHY_WAIT_CLK;
      PHY_WAIT_CLK:
        if (ref_clk_active_i && supplies_ok)
          state_nxt = PHY_WAIT_PLL;
      PHY_WAIT_PLL:
        if (pll_locked_i)
          state_nxt = PHY_WAIT_STP;
      PHY_WAIT_STP:
        if (!lnk.stp)
          state_nxt = PHY_SYNC;
      PHY_SYNC:
        state_nxt = PHY_SYNC;
      default:
        state_nxt = PHY_RESET;
    endcase
    if (hold_reset || !supplies_ok)
      state_nxt = PHY_RESET;
  end

  assign dir_nxt = (state_nxt == PHY_WAIT_PLL) || (state_nxt == PHY_WAIT_STP);

  assign lines = analog_supply_ok_i ? line_raw_i : 2'h0;

  assign id_fall = id_prev_r && !id_pin_i && (state_r == PHY_SYNC);

  assign otg_nxt = hold_reset ? `OTG_CTRL_RST :
                   {regs_r[0][7:1], lnk.id_bias_enable};

  always_comb
  begin
    stat_nxt = `INT_STAT_RST;
    if (!hold_reset)
    begin
      stat_nxt[`INT_STAT_ID_GND_BIT] = id_pin_i;
      stat_nxt[`INT_STAT_LINE_LO +: 2] = lines;
    end
  end

  // Data bus is only driven while DIR is high, so the link never fights it.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r <= PHY_RESET;
      dir_r <= 1'b0;
    end
    else if (ce_i)
    begin
      state_r <= state_nxt;
      dir_r <= dir_nxt;
    end
  end

  // The previous level resets to floating, so a release gives no false fall.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      id_prev_r <= 1'b1;
      id_int_r <= 1'b0;
    end
    else if (ce_i)
    begin
      id_prev_r <= id_pin_i;
      id_int_r <= id_fall;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      regs_r[0] <= `OTG_CTRL_RST;
      regs_r[1] <= `INT_STAT_RST;
    end
    else if (ce_i)
    begin
      regs_r[0] <= otg_nxt;
      regs_r[1] <= stat_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      in_reset_o <= 1'b1;
      sync_mode_o <= 1'b0;
    end
    else if (ce_i)
    begin
      in_reset_o <= (state_nxt == PHY_RESET);
      sync_mode_o <= (state_nxt == PHY_SYNC);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      id_bias_o <= 1'b0;
      id_grounded_o <= 1'b0;
      line_state_o <= 2'h0;
    end
    else if (ce_i)
    begin
      id_bias_o <= otg_nxt[`OTG_ID_BIAS_BIT];
      id_grounded_o <= !stat_nxt[`INT_STAT_ID_GND_BIT] && !hold_reset;
      line_state_o <= stat_nxt[`INT_STAT_LINE_LO +: 2];
    end
  end

  assign lnk.dir = dir_r;
  assign lnk.phy_data = `ULPI_IDLE;
  assign lnk.phy_data_oe = dir_r;
  assign lnk.int_status = regs_r[1];
  assign lnk.id_int = id_int_r;

endmodule

// *** design/ulpi_su_cfg.svh ***
`ifndef ULPI_SU_CFG_SVH
`define ULPI_SU_CFG_SVH

// Clock and timing figures.
`define CLK_PERIOD_NS 4
`define RST_LOW_MIN_NS 1000
`define RST_LOW_CYC ((`RST_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ID_WAIT_MS 50
`define ID_WAIT_CYC ((`ID_WAIT_MS * 1000000) / `CLK_PERIOD_NS)

// Interface register defaults and field positions.
`define OTG_CTRL_RST 8'h00
`define OTG_ID_BIAS_BIT 0
`define INT_STAT_RST 8'h00
`define INT_STAT_ID_GND_BIT 4
`define INT_STAT_LINE_LO 0
`define ULPI_IDLE 8'h00

`endif

// *** design/ulpi_su_pkg.sv ***
package ulpi_su_pkg;

  typedef enum logic [2:0] {
    PHY_RESET    = 3'h0,
    PHY_WAIT_CLK = 3'h1,
    PHY_WAIT_PLL = 3'h2,
    PHY_WAIT_STP = 3'h3,
    PHY_SYNC     = 3'h4
  } phy_state_e;

  typedef enum logic [2:0] {
    LNK_RST_LOW  = 3'h0,
    LNK_WAIT_DIR = 3'h1,
    LNK_IDLE     = 3'h2,
    LNK_RUN      = 3'h3
  } lnk_state_e;

  typedef logic [7:0] ulpi_byte_t;

endpackage

// *** design/ulpi_su_if.sv ***
`include "ulpi_su_cfg.svh"

interface ulpi_su_if;
  import ulpi_su_pkg::*;

  logic ext_reset_n;
  logic stp;
  logic dir;
  ulpi_byte_t phy_data;
  logic phy_data_oe;
  ulpi_byte_t lnk_data;
  logic lnk_data_oe;
  logic id_bias_enable;
  ulpi_byte_t int_status;
  logic id_int;
  ulpi_byte_t data_bus;

  // Resolved bus level; an undriven bus reads as the idle pattern.
  assign data_bus = phy_data_oe ? phy_data : (lnk_data_oe ? lnk_data : `ULPI_IDLE);

  modport phy (
    input ext_reset_n,
    input stp,
    input lnk_data,
    input lnk_data_oe,
    input id_bias_enable,
    output dir,
    output phy_data,
    output phy_data_oe,
    output int_status,
    output id_int
  );

  modport link (
    output ext_reset_n,
    output stp,
    output lnk_data,
    output lnk_data_oe,
    output id_bias_enable,
    input dir,
    input phy_data,
    input phy_data_oe,
    input int_status,
    input id_int
  );
endinterface

// *** design/ulpi_link_startup.sv ***
`include "ulpi_su_cfg.svh"

module ulpi_link_startup
  import ulpi_su_pkg::*;
#(
  parameter int unsigned ID_WAIT = `ID_WAIT_CYC
)
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic supplies_stable_i,
  input wire logic ready_i,
  input wire logic reset_req_i,
  input wire logic stp_hold_i,
  input wire logic id_check_i,
  ulpi_su_if.link phy,
  output logic bus_ready_o,
  output logic id_done_o,
  output logic cable_a_o,
  output logic id_int_o
);

  lnk_state_e state_r;
  lnk_state_e state_nxt;
  logic [7:0] rst_cnt_r;
  logic dir_seen_r;
  logic ext_rst_n_r;
  logic stp_r;
  logic idle_oe_r;
  logic bias_r;
  logic [23:0] id_cnt_r;
  logic rst_done;
  logic id_wait_done;

  assign rst_done = rst_cnt_r >= 8'(`RST_LOW_CYC);
  assign id_wait_done = id_cnt_r >= 24'(ID_WAIT);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      LNK_RST_LOW:
        if (rst_done && supplies_stable_i && ready_i)
          state_nxt = LNK_WAIT_DIR;
      LNK_WAIT_DIR:
        if (dir_seen_r && !phy.dir && !stp_r)
          state_nxt = LNK_IDLE;
      LNK_IDLE:
        state_nxt = LNK_RUN;
      LNK_RUN:
        if (reset_req_i)
          state_nxt = LNK_RST_LOW;
      default:
        state_nxt = LNK_RST_LOW;
    endcase
  end

  // Reset comes up low, so the pin is defined from the first edge onward.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r <= LNK_RST_LOW;
      rst_cnt_r <= 8'h00;
      dir_seen_r <= 1'b0;
      ext_rst_n_r <= 1'b0;
      stp_r <= 1'b0;
      idle_oe_r <= 1'b0;
    end
    else if (ce_i)
    begin
      state_r <= state_nxt;
      if (state_nxt != LNK_RST_LOW)
        rst_cnt_r <= 8'h00;
      else if (!rst_done)
        rst_cnt_r <= rst_cnt_r + 8'h01;
      dir_seen_r <= (state_r == LNK_WAIT_DIR) && (dir_seen_r || phy.dir);
      ext_rst_n_r <= (state_nxt != LNK_RST_LOW);
      stp_r <= (state_nxt == LNK_WAIT_DIR) && stp_hold_i;
      idle_oe_r <= (state_nxt == LNK_IDLE);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bias_r <= 1'b0;
      id_cnt_r <= 24'h000000;
      id_done_o <= 1'b0;
      cable_a_o <= 1'b0;
    end
    else if (ce_i)
    begin
      id_done_o <= 1'b0;
      if (state_r != LNK_RUN)
      begin
        bias_r <= 1'b0;
        id_cnt_r <= 24'h000000;
      end
      else if (id_check_i && !bias_r)
      begin
        bias_r <= 1'b1;
        id_cnt_r <= 24'h000000;
      end
      else if (bias_r && !id_wait_done)
        id_cnt_r <= id_cnt_r + 24'h000001;
      else if (bias_r)
      begin
        bias_r <= 1'b0;
        id_done_o <= 1'b1;
        cable_a_o <= !phy.int_status[`INT_STAT_ID_GND_BIT];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bus_ready_o <= 1'b0;
      id_int_o <= 1'b0;
    end
    else if (ce_i)
    begin
      bus_ready_o <= (state_nxt == LNK_RUN);
      id_int_o <= phy.id_int && (state_r == LNK_RUN);
    end
  end

  assign phy.ext_reset_n = ext_rst_n_r;
  assign phy.stp = stp_r;
  assign phy.lnk_data = `ULPI_IDLE;
  assign phy.lnk_data_oe = idle_oe_r;
  assign phy.id_bias_enable = bias_r;

endmodule

// *** verification/ulpi_su_checker.sv ***
`include "ulpi_su_cfg.svh"
module ulpi_su_checker
  import ulpi_su_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ext_reset_n_i,
  input wire logic stp_i,
  input wire logic dir_i,
  input wire logic lnk_data_oe_i,
  input wire logic id_bias_enable_i,
  input wire logic id_int_i,
  input wire ulpi_byte_t data_bus_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RLOW = `RST_LOW_CYC;
  int low_cnt_r;
  int low_cnt_nxt;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  // A counter, since the low time is far beyond what a repetition may unroll.
  assign low_cnt_nxt = ext_reset_n_i ? 0 : low_cnt_r + 1;
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      low_cnt_r <= 0;
    else
      low_cnt_r <= low_cnt_nxt;
  end
  dir_idle_a:
    assert property (dir_i |-> !lnk_data_oe_i && data_bus_i == 8'h00)
      else $error("Bus not idle under dir.");
  stp_hold_a:
    assert property (dir_i && stp_i |=> dir_i) else $error("Dir fell while stp high.");
  dir_fall_a:
    assert property ($fell(dir_i) |-> !$past(stp_i)) else $error("Dir fell without stp low.");
  link_idle_a:
    assert property ($fell(dir_i) |=> (lnk_data_oe_i && data_bus_i == 8'h00) ##1 !lnk_data_oe_i)
      else $error("No single idle cycle.");
  rst_time_a:
    assert property ($rose(ext_reset_n_i) |-> low_cnt_r >= RLOW) else $error("Pulse too short.");
  pin_low_a:
    assert property (!ext_reset_n_i [*3] |=> !dir_i) else $error("Pin low kept dir.");
  start_gap_a:
    assert property ($rose(ext_reset_n_i) |-> !dir_i [*4]) else $error("Start too early.");
  bias_wait_a:
    assert property ($rose(id_bias_enable_i) |-> id_bias_enable_i [*8])
      else $error("Bias short.");
  id_pulse_a:
    assert property (id_int_i |=> !id_int_i) else $error("Interrupt longer than one cycle.");
  cover property ($fell(dir_i));
  cover property ($rose(id_bias_enable_i));
  cover property (id_int_i);
  cover property ($rose(ext_reset_n_i));
endmodule

// *** verification/ulpi_reset_startup_id_detect_tb_top.sv ***
module ulpi_reset_startup_id_detect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, resetn_i = 0, ce = 1, core = 0, io = 0, ana = 0, refc = 0, pll = 0;
  logic idp = 1, sup = 0, rdy = 0, rreq = 0, hold = 1, idchk = 0;
  logic [1:0] line = 0;
  logic [1:0] ls;
  logic in_rst, sync, bias, idg, busr, idd, cab, idi;
  int errors = 0, compares = 0, seed = 57, n;
  logic [7:0] notes[$];
  ulpi_su_if bus_if ();
  always #2 mclk_i = ~mclk_i;
  ulpi_phy_startup ulpi_phy_startup_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce),
    .core_supply_ok_i(core), .io_supply_ok_i(io), .analog_supply_ok_i(ana),
    .ref_clk_active_i(refc), .pll_locked_i(pll), .id_pin_i(idp), .line_raw_i(line),
    .lnk(bus_if), .in_reset_o(in_rst), .sync_mode_o(sync), .id_bias_o(bias),
    .id_grounded_o(idg), .line_state_o(ls));
  ulpi_link_startup #(.ID_WAIT(20)) ulpi_link_startup_i (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .ce_i(ce), .supplies_stable_i(sup), .ready_i(rdy),
    .reset_req_i(rreq), .stp_hold_i(hold), .id_check_i(idchk), .phy(bus_if),
    .bus_ready_o(busr), .id_done_o(idd), .cable_a_o(cab), .id_int_o(idi));
  ulpi_su_checker ulpi_su_checker_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .ext_reset_n_i(bus_if.ext_reset_n), .stp_i(bus_if.stp), .dir_i(bus_if.dir),
    .lnk_data_oe_i(bus_if.lnk_data_oe), .id_bias_enable_i(bus_if.id_bias_enable),
    .id_int_i(bus_if.id_int), .data_bus_i(bus_if.data_bus));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_i);
  endtask
  task automatic wait_ready();
    n = 0;
    while (busr !== 1'b1 && n < 2000)
    begin
      cyc(1);
      n++;
    end
    check(busr, 8'h01);
    check(sync, 8'h01);
  endtask
  // Results are matched in order, so a missing pulse shifts every later note.
  always @(negedge mclk_i)
    if (idd === 1'b1 || idi === 1'b1)
    begin
      if (notes.size() == 0)
        check(8'hFF, 8'h00);
      else
        check({5'h00, idi, idd, cab}, notes.pop_front());
    end
  initial
  begin
    #100000;
    errors++;
    end_sim();
  end
  initial
  begin
    cyc(4);
    check(bus_if.ext_reset_n, 8'h00);
    resetn_i = 1;
    cyc(5);
    check(in_rst, 8'h01);
    check(bus_if.ext_reset_n, 8'h00);
    core = 1;
    io = 1;
    sup = 1;
    cyc(300);
    check(bus_if.ext_reset_n, 8'h00);
    check(in_rst, 8'h01);
    rdy = 1;
    cyc(10);
    check(in_rst, 8'h00);
    check(bus_if.dir, 8'h00);
    refc = 1;
    cyc(5);
    check(bus_if.dir, 8'h01);
    pll = 1;
    cyc(10);
    check(bus_if.dir, 8'h01);
    hold = 0;
    wait_ready();
    line = 2'($random(seed));
    cyc(3);
    check(ls, 8'h00);
    ana = 1;
    cyc(3);
    check(ls, line);
    repeat (8)
    begin
      n = $random(seed);
      if (idp && !n[0])
        notes.push_back(8'h04);
      idp = n[0];
      cyc(6);
      check(idg, !idp);
      check(bus_if.int_status, {3'h0, idp, 2'h0, line});
      notes.push_back({7'h01, !idp});
      idchk = 1;
      cyc(1);
      idchk = 0;
      cyc(3);
      check(bias, 8'h01);
      cyc(30);
    end
    check(bias, 8'h00);
    n = idp;
    ce = 0;
    idp = !idp;
    cyc(4);
    check(idg, !n[0]);
    idp = n[0];
    ce = 1;
    cyc(2);
    rreq = 1;
    cyc(1);
    rreq = 0;
    cyc(20);
    check(in_rst, 8'h01);
    check(sync, 8'h00);
    check(idg, 8'h00);
    wait_ready();
    resetn_i = 0;
    cyc(2);
    check(in_rst, 8'h01);
    check(bus_if.ext_reset_n, 8'h00);
    check(bias, 8'h00);
    resetn_i = 1;
    wait_ready();
    check(8'(notes.size()), 8'h00);
    cyc(10);
    end_sim();
  end
endmodule
